// ==== hdl/tas_pkg.sv ====
// Shared constants, field layout and helper functions of the order execution unit
package tas_pkg;
	localparam int WORD_W = 52;
	localparam int ADDR_W = 11;
	localparam int MAG_W = 44;
	localparam int ACC_W = 96;
	localparam int ACC_DIGITS = 24;
	localparam int NUM_DIGITS = 11;

	// Order word field positions
	localparam int F_DES_A = 50;
	localparam int F_DES_B = 49;
	localparam int F_DES_C = 48;
	localparam int F_OP_LO = 40;
	localparam int F_A_LO = 28;
	localparam int F_B_LO = 16;
	localparam int F_C_LO = 4;
	localparam int F_BH_LO = 24;
	localparam int F_BT_LO = 20;

	// Fixed memory locations
	localparam logic [10:0] ADDR_OVERFLOW_CALL = 11'h7C4;
	localparam logic [10:0] ADDR_DIV_FAULT_CALL = 11'h7C2;
	localparam logic [10:0] ADDR_SELECT_ORDER_HOLD = 11'h7CA;
	localparam logic [10:0] ADDR_PRODUCT_LOW_REMAINDER = 11'h7CB;
	localparam logic [10:0] ADDR_MARKER_WORD_HOLD = 11'h7CD;

	// Sign codes of a numeric word
	localparam logic [3:0] SIGN_POS = 4'h0;
	localparam logic [3:0] SIGN_NEG = 4'h1;

	// Operation codes
	localparam logic [7:0] OP_SUM = 8'h01;
	localparam logic [7:0] OP_DIFFERENCE = 8'h02;
	localparam logic [7:0] OP_PRODUCT = 8'h03;
	localparam logic [7:0] OP_QUOTIENT = 8'h04;
	localparam logic [7:0] OP_BITWISE_MERGE = 8'h05;
	localparam logic [7:0] OP_LEFT_KEEP_SIGN = 8'h10;
	localparam logic [7:0] OP_RIGHT_KEEP_SIGN = 8'h11;
	localparam logic [7:0] OP_LEFT_WHOLE_NUMERIC = 8'h12;
	localparam logic [7:0] OP_RIGHT_WHOLE_NUMERIC = 8'h13;
	localparam logic [7:0] OP_LEFT_CHARACTERS = 8'h14;
	localparam logic [7:0] OP_RIGHT_CHARACTERS = 8'h15;
	localparam logic [7:0] OP_TRANSFER_IN = 8'hF3;
	localparam logic [7:0] OP_DOUBLE_TRANSFER_SELECT = 8'hFA;
	localparam logic [7:0] OP_TRANSFER_SELECT = 8'hEB;
	localparam logic [7:0] OP_TRANSFER_OUT = 8'h20;

	localparam logic [3:0] EXTRA_SHIFT_DIGIT = 4'h5;
	localparam logic [3:0] DIGIT_MAX = 4'h9;
	localparam logic [3:0] DIGIT_COUNT_INIT = 4'hB;
	// Five lands in the top digit of the lower half, digit ten
	localparam logic [95:0] ROUND_ADDEND = 96'h0000_0000_0000_0500_0000_0000;

	function automatic logic [3:0] wc_of(input logic [47:0] d);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 48; i++) begin
			n = n + {3'h0, d[i]};
		end
		return n;
	endfunction

	function automatic logic [51:0] make_word(input logic [47:0] d);
		return {d, wc_of(d)};
	endfunction

	function automatic logic num_valid(input logic [51:0] w);
		logic ok;
		ok = (w[51:48] == SIGN_POS) || (w[51:48] == SIGN_NEG);
		for (int i = 1; i <= 11; i++) begin
			if (w[i*4 +: 4] > DIGIT_MAX) begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction

	function automatic logic [10:0] addr_of(input logic d, input logic [11:0] htu);
		return {10'h000, d} * 11'h3E8 + {7'h00, htu[11:8]} * 11'h064 + {7'h00, htu[7:4]} * 11'h00A
			+ {7'h00, htu[3:0]};
	endfunction

	function automatic logic [5:0] count32(input logic [4:0] c);
		return (c == 5'h00) ? 6'h20 : {1'b0, c};
	endfunction

	function automatic logic is_marker(input logic [51:0] w);
		return w[51:50] == 2'h0;
	endfunction
endpackage

// ==== hdl/tas_bcd_addsub.sv ====
// Decimal adder and subtracter over packed digit nibbles
`timescale 1ns/1ps
module tas_bcd_addsub #(
	parameter int DIGITS = 24
) (
	input wire logic [DIGITS*4-1:0] a,
	input wire logic [DIGITS*4-1:0] b,
	input wire logic sub,
	output logic [DIGITS*4-1:0] sum,
	output logic cout
);
	// Subtraction adds the nines complement plus one; cout high means no borrow
	always_comb begin
		logic [4:0] s;
		logic [3:0] bd;
		logic c;
		s = 5'h00;
		bd = 4'h0;
		c = sub;
		sum = '0;
		for (int i = 0; i < DIGITS; i++) begin
			bd = sub ? (4'h9 - b[i*4 +: 4]) : b[i*4 +: 4];
			s = {1'b0, a[i*4 +: 4]} + {1'b0, bd} + {4'h0, c};
			if (s > 5'h09) begin
				sum[i*4 +: 4] = 4'(s - 5'h0A);
				c = 1'b1;
			end else begin
				sum[i*4 +: 4] = s[3:0];
				c = 1'b0;
			end
		end
		cout = c;
	end
endmodule

// ==== hdl/tas_exec_unit.sv ====
// Three-address arithmetic and shift execution unit facing core memory
`timescale 1ns/1ps
// Functional notes
// - Decode opcode and three four-digit address fields
// - Address fields map to locations 0 to 1999
// - Sum writes C; overflow calls fixed routine
// - Difference A minus B; overflow calls fixed routine
// - Product upper half to C, lower to remainder
// - Round by adding five at lower top digit
// - Quotient B over A; remainder to remainder word
// - Dividend not below divisor calls fault routine
// - Merge takes A bits where mask B set
// - Product leaves seven A and four A unsigned
// - Bad digit or sign in product/quotient flags error
// - Sign-keeping shifts move digits only, zero to twelve
// - Whole numeric shifts include sign position
// - Character shifts include sign, A unchanged
// - Hundreds digit nibble count; tens five adds two bits, except in sign-keeping shifts
// - Buffer orders split B into index and count
// - Index and count five bits, zero means 32
// - Word with two top bits zero is sentinel
module tas_exec_unit (
	input wire logic clock,
	input wire logic rst,
	input wire logic order_valid,
	output logic order_ready,
	input wire logic [51:0] order_word,
	output logic mem_req,
	output logic mem_we,
	output logic [10:0] mem_addr,
	output logic [51:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [51:0] mem_rdata,
	output logic order_done,
	output logic call_valid,
	output logic [10:0] call_addr,
	output logic weight_count_error,
	output logic result_is_marker,
	output logic [5:0] transfer_control_index,
	output logic [5:0] transfer_word_count
);
	typedef enum logic [4:0] {
		IDLE, FETCH_A, FETCH_B, FETCH_C, EXEC, ARITH, ARITH2, MUL_SHIFT, MUL_ADD, ROUND,
		SIDE1, SIDE2, SIDE3, SIDE4, DIV_CHK, DIV_SHIFT, DIV_SUB, WR_C, WR_REM, WR_SEL, WR_MARK
	} tas_state_t;

	tas_state_t state_r, state_nxt;
	logic [7:0] op_r, op_nxt;
	logic [10:0] addr_a_r, addr_a_nxt, addr_b_r, addr_b_nxt, addr_c_r, addr_c_nxt;
	logic [3:0] bh_r, bh_nxt, bt_r, bt_nxt;
	logic [51:0] wa_r, wa_nxt, wb_r, wb_nxt, wc_r, wc_nxt;
	logic [95:0] acc_r, acc_nxt, tmp_r, tmp_nxt, tmp4_r, tmp4_nxt;
	logic [43:0] mq_r, mq_nxt, quot_r, quot_nxt;
	logic [3:0] cnt_r, cnt_nxt, rep_r, rep_nxt;
	logic neg_r, neg_nxt;
	logic mem_we_r, mem_we_nxt;
	logic [10:0] mem_addr_r, mem_addr_nxt;
	logic [51:0] mem_wdata_r, mem_wdata_nxt;
	logic done_r, done_nxt, call_r, call_nxt, wce_r, wce_nxt, marker_r, marker_nxt;
	logic [10:0] call_addr_r, call_addr_nxt;
	logic [5:0] idx_r, idx_nxt, wcnt_r, wcnt_nxt;

	// Operand views
	wire logic [95:0] mag_a = {52'h0, wa_r[47:4]};
	wire logic [95:0] mag_b = {52'h0, wb_r[47:4]};
	wire logic neg_a = wa_r[51:48] == tas_pkg::SIGN_NEG;
	wire logic neg_b = wb_r[51:48] == tas_pkg::SIGN_NEG;
	wire logic neg_b_eff = neg_b ^ (op_r == tas_pkg::OP_DIFFERENCE);
	wire logic need_b = (op_r == tas_pkg::OP_SUM) || (op_r == tas_pkg::OP_DIFFERENCE) || (op_r == tas_pkg::OP_PRODUCT)
		|| (op_r == tas_pkg::OP_QUOTIENT) || (op_r == tas_pkg::OP_BITWISE_MERGE);
	wire logic is_shift = (op_r[7:4] == 4'h1) && (op_r[3:0] <= 4'h5);
	wire logic is_buffer = (op_r == tas_pkg::OP_TRANSFER_IN) || (op_r == tas_pkg::OP_DOUBLE_TRANSFER_SELECT)
		|| (op_r == tas_pkg::OP_TRANSFER_SELECT) || (op_r == tas_pkg::OP_TRANSFER_OUT);
	wire logic [7:0] in_op = order_word[47:40];
	wire logic bad_operand = !tas_pkg::num_valid(wa_r) || !tas_pkg::num_valid(wb_r);

	// Shift amount: nibble count plus optional two-bit step
	wire logic keep_sign = (op_r == tas_pkg::OP_LEFT_KEEP_SIGN) || (op_r == tas_pkg::OP_RIGHT_KEEP_SIGN);
	wire logic [6:0] sh_digits = {1'b0, bh_r, 2'h0};
	wire logic [6:0] sh_full = sh_digits + ((bt_r == tas_pkg::EXTRA_SHIFT_DIGIT) ? 7'h02 : 7'h00);
	wire logic shift_left = !op_r[0];
	wire logic [43:0] ks_field = shift_left ? (wa_r[47:4] << sh_digits) : (wa_r[47:4] >> sh_digits);
	wire logic [47:0] wh_field = shift_left ? (wa_r[51:4] << sh_full) : (wa_r[51:4] >> sh_full);
	wire logic [47:0] shift_res = keep_sign ? {wa_r[51:48], ks_field} : wh_field;
	wire logic [47:0] merge_res = (wa_r[51:4] & wb_r[51:4]) | (wc_r[51:4] & ~wb_r[51:4]);

	// Single shared decimal adder; operands chosen by the current step
	logic [95:0] add_a, add_b, add_sum;
	logic add_sub, add_cout;
	always_comb begin
		add_a = '0;
		add_b = '0;
		add_sub = 1'b0;
		case (state_r)
			ARITH: begin
				add_a = mag_a;
				add_b = mag_b;
				add_sub = neg_a != neg_b_eff;
			end
			ARITH2: begin
				add_a = mag_b;
				add_b = mag_a;
				add_sub = 1'b1;
			end
			MUL_ADD: begin
				add_a = acc_r;
				add_b = mag_a;
			end
			ROUND: begin
				add_a = acc_r;
				add_b = tas_pkg::ROUND_ADDEND;
			end
			DIV_CHK: begin
				add_a = mag_b;
				add_b = mag_a;
				add_sub = 1'b1;
			end
			DIV_SUB: begin
				add_a = acc_r;
				add_b = mag_a;
				add_sub = 1'b1;
			end
			SIDE1: begin
				add_a = mag_a;
				add_b = mag_a;
			end
			SIDE2: begin
				add_a = tmp_r;
				add_b = tmp_r;
			end
			SIDE3: begin
				add_a = tmp4_r;
				add_b = tmp_r;
			end
			SIDE4: begin
				add_a = tmp_r;
				add_b = mag_a;
			end
			default: begin
				add_sub = 1'b0;
			end
		endcase
	end

	tas_bcd_addsub #(.DIGITS(tas_pkg::ACC_DIGITS)) u_add (
		.a(add_a),
		.b(add_b),
		.sub(add_sub),
		.sum(add_sum),
		.cout(add_cout)
	);

	wire logic [3:0] res_sign = neg_r ? tas_pkg::SIGN_NEG : tas_pkg::SIGN_POS;
	wire logic sum_ovf = add_sum[47:44] != 4'h0;

	always_comb begin
		state_nxt = state_r;
		op_nxt = op_r;
		addr_a_nxt = addr_a_r;
		addr_b_nxt = addr_b_r;
		addr_c_nxt = addr_c_r;
		bh_nxt = bh_r;
		bt_nxt = bt_r;
		wa_nxt = wa_r;
		wb_nxt = wb_r;
		wc_nxt = wc_r;
		acc_nxt = acc_r;
		tmp_nxt = tmp_r;
		tmp4_nxt = tmp4_r;
		mq_nxt = mq_r;
		quot_nxt = quot_r;
		cnt_nxt = cnt_r;
		rep_nxt = rep_r;
		neg_nxt = neg_r;
		mem_we_nxt = mem_we_r;
		mem_addr_nxt = mem_addr_r;
		mem_wdata_nxt = mem_wdata_r;
		done_nxt = 1'b0;
		call_nxt = 1'b0;
		call_addr_nxt = call_addr_r;
		wce_nxt = 1'b0;
		marker_nxt = marker_r;
		idx_nxt = idx_r;
		wcnt_nxt = wcnt_r;
		case (state_r)
			IDLE: begin
				if (order_valid) begin
					op_nxt = in_op;
					addr_a_nxt = tas_pkg::addr_of(order_word[tas_pkg::F_DES_A], order_word[tas_pkg::F_A_LO +: 12]);
					addr_b_nxt = tas_pkg::addr_of(order_word[tas_pkg::F_DES_B], order_word[tas_pkg::F_B_LO +: 12]);
					addr_c_nxt = tas_pkg::addr_of(order_word[tas_pkg::F_DES_C], order_word[tas_pkg::F_C_LO +: 12]);
					bh_nxt = order_word[tas_pkg::F_BH_LO +: 4];
					bt_nxt = order_word[tas_pkg::F_BT_LO +: 4];
					idx_nxt = tas_pkg::count32({order_word[tas_pkg::F_DES_B], order_word[tas_pkg::F_BH_LO +: 4]});
					wcnt_nxt = tas_pkg::count32(order_word[tas_pkg::F_B_LO +: 5]);
					mem_we_nxt = 1'b0;
					mem_addr_nxt = tas_pkg::addr_of(order_word[tas_pkg::F_DES_A], order_word[tas_pkg::F_A_LO +: 12]);
					state_nxt = FETCH_A;
				end
			end
			FETCH_A: begin
				// Buffer and unknown orders finish here; only the B split is kept
				if (is_buffer || (!need_b && !is_shift)) begin
					done_nxt = 1'b1;
					state_nxt = IDLE;
				end else if (mem_ack) begin
					wa_nxt = mem_rdata;
					mem_addr_nxt = addr_b_r;
					state_nxt = need_b ? FETCH_B : EXEC;
				end
			end
			FETCH_B: begin
				if (mem_ack) begin
					wb_nxt = mem_rdata;
					mem_addr_nxt = addr_c_r;
					state_nxt = (op_r == tas_pkg::OP_BITWISE_MERGE) ? FETCH_C : EXEC;
				end
			end
			FETCH_C: begin
				if (mem_ack) begin
					wc_nxt = mem_rdata;
					state_nxt = EXEC;
				end
			end
			EXEC: begin
				mem_addr_nxt = addr_c_r;
				mem_we_nxt = 1'b1;
				neg_nxt = neg_a ^ neg_b;
				acc_nxt = '0;
				mq_nxt = wb_r[47:4];
				cnt_nxt = tas_pkg::DIGIT_COUNT_INIT;
				if (((op_r == tas_pkg::OP_PRODUCT) || (op_r == tas_pkg::OP_QUOTIENT)) && bad_operand) begin
					wce_nxt = 1'b1;
					done_nxt = 1'b1;
					state_nxt = IDLE;
				end else if (op_r == tas_pkg::OP_PRODUCT) begin
					state_nxt = MUL_SHIFT;
				end else if (op_r == tas_pkg::OP_QUOTIENT) begin
					state_nxt = DIV_CHK;
				end else if (op_r == tas_pkg::OP_BITWISE_MERGE) begin
					mem_wdata_nxt = tas_pkg::make_word(merge_res);
					state_nxt = WR_C;
				end else if (is_shift) begin
					mem_wdata_nxt = tas_pkg::make_word(shift_res);
					state_nxt = WR_C;
				end else begin
					state_nxt = ARITH;
				end
			end
			ARITH: begin
				// Unlike signs subtract magnitudes; a borrow means B is larger, so redo reversed
				if (add_sub && !add_cout) begin
					state_nxt = ARITH2;
				end else if (sum_ovf) begin
					call_nxt = 1'b1;
					call_addr_nxt = tas_pkg::ADDR_OVERFLOW_CALL;
					done_nxt = 1'b1;
					state_nxt = IDLE;
				end else begin
					mem_wdata_nxt = tas_pkg::make_word({wa_r[51:48], add_sum[43:0]});
					state_nxt = WR_C;
				end
			end
			ARITH2: begin
				mem_wdata_nxt = tas_pkg::make_word({neg_b_eff ? tas_pkg::SIGN_NEG : tas_pkg::SIGN_POS, add_sum[43:0]});
				state_nxt = WR_C;
			end
			MUL_SHIFT: begin
				// One multiplier digit per pass, most significant first
				if (cnt_r == 4'h0) begin
					state_nxt = ROUND;
				end else begin
					acc_nxt = {acc_r[91:0], 4'h0};
					rep_nxt = mq_r[43:40];
					mq_nxt = {mq_r[39:0], 4'h0};
					cnt_nxt = cnt_r - 4'h1;
					state_nxt = MUL_ADD;
				end
			end
			MUL_ADD: begin
				if (rep_r == 4'h0) begin
					state_nxt = MUL_SHIFT;
				end else begin
					acc_nxt = add_sum;
					rep_nxt = rep_r - 4'h1;
				end
			end
			ROUND: begin
				acc_nxt = add_sum;
				state_nxt = SIDE1;
			end
			SIDE1: begin
				tmp_nxt = add_sum;
				state_nxt = SIDE2;
			end
			SIDE2: begin
				tmp4_nxt = add_sum;
				state_nxt = SIDE3;
			end
			SIDE3: begin
				tmp_nxt = add_sum;
				state_nxt = SIDE4;
			end
			SIDE4: begin
				tmp_nxt = add_sum;
				mem_wdata_nxt = tas_pkg::make_word({res_sign, acc_r[87:44]});
				state_nxt = WR_C;
			end
			DIV_CHK: begin
				if (add_cout) begin
					call_nxt = 1'b1;
					call_addr_nxt = tas_pkg::ADDR_DIV_FAULT_CALL;
					done_nxt = 1'b1;
					state_nxt = IDLE;
				end else begin
					acc_nxt = mag_b;
					quot_nxt = '0;
					state_nxt = DIV_SHIFT;
				end
			end
			DIV_SHIFT: begin
				if (cnt_r == 4'h0) begin
					mem_wdata_nxt = tas_pkg::make_word({res_sign, quot_r});
					state_nxt = WR_C;
				end else begin
					acc_nxt = {acc_r[91:0], 4'h0};
					quot_nxt = {quot_r[39:0], 4'h0};
					cnt_nxt = cnt_r - 4'h1;
					state_nxt = DIV_SUB;
				end
			end
			DIV_SUB: begin
				// Remainder stays below the divisor, so a digit never passes nine
				if (add_cout) begin
					acc_nxt = add_sum;
					quot_nxt = {quot_r[43:4], quot_r[3:0] + 4'h1};
				end else begin
					state_nxt = DIV_SHIFT;
				end
			end
			WR_C: begin
				if (mem_ack) begin
					marker_nxt = tas_pkg::is_marker(mem_wdata_r);
					if ((op_r == tas_pkg::OP_PRODUCT) || (op_r == tas_pkg::OP_QUOTIENT)) begin
						mem_addr_nxt = tas_pkg::ADDR_PRODUCT_LOW_REMAINDER;
						mem_wdata_nxt = tas_pkg::make_word({(op_r == tas_pkg::OP_PRODUCT) ? res_sign : wb_r[51:48],
							acc_r[43:0]});
						state_nxt = WR_REM;
					end else begin
						done_nxt = 1'b1;
						state_nxt = IDLE;
					end
				end
			end
			WR_REM: begin
				if (mem_ack) begin
					if ((op_r == tas_pkg::OP_PRODUCT) && (addr_c_r != tas_pkg::ADDR_SELECT_ORDER_HOLD)) begin
						mem_addr_nxt = tas_pkg::ADDR_SELECT_ORDER_HOLD;
						mem_wdata_nxt = tas_pkg::make_word(tmp_r[47:0]);
						state_nxt = WR_SEL;
					end else if ((op_r == tas_pkg::OP_PRODUCT) && (addr_c_r != tas_pkg::ADDR_MARKER_WORD_HOLD)) begin
						mem_addr_nxt = tas_pkg::ADDR_MARKER_WORD_HOLD;
						mem_wdata_nxt = tas_pkg::make_word(tmp4_r[47:0]);
						state_nxt = WR_MARK;
					end else begin
						done_nxt = 1'b1;
						state_nxt = IDLE;
					end
				end
			end
			WR_SEL: begin
				if (mem_ack) begin
					if (addr_c_r != tas_pkg::ADDR_MARKER_WORD_HOLD) begin
						mem_addr_nxt = tas_pkg::ADDR_MARKER_WORD_HOLD;
						mem_wdata_nxt = tas_pkg::make_word(tmp4_r[47:0]);
						state_nxt = WR_MARK;
					end else begin
						done_nxt = 1'b1;
						state_nxt = IDLE;
					end
				end
			end
			WR_MARK: begin
				if (mem_ack) begin
					done_nxt = 1'b1;
					state_nxt = IDLE;
				end
			end
			default: begin
				state_nxt = IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_r <= IDLE;
			mem_we_r <= 1'b0;
			mem_addr_r <= '0;
			mem_wdata_r <= '0;
			done_r <= 1'b0;
			call_r <= 1'b0;
			call_addr_r <= '0;
			wce_r <= 1'b0;
			marker_r <= 1'b0;
			idx_r <= '0;
			wcnt_r <= '0;
		end else begin
			state_r <= state_nxt;
			mem_we_r <= mem_we_nxt;
			mem_addr_r <= mem_addr_nxt;
			mem_wdata_r <= mem_wdata_nxt;
			done_r <= done_nxt;
			call_r <= call_nxt;
			call_addr_r <= call_addr_nxt;
			wce_r <= wce_nxt;
			marker_r <= marker_nxt;
			idx_r <= idx_nxt;
			wcnt_r <= wcnt_nxt;
		end
	end

	// Datapath holding registers need no reset; control never reads them before loading
	always_ff @(posedge clock) begin
		op_r <= op_nxt;
		addr_a_r <= addr_a_nxt;
		addr_b_r <= addr_b_nxt;
		addr_c_r <= addr_c_nxt;
		bh_r <= bh_nxt;
		bt_r <= bt_nxt;
		wa_r <= wa_nxt;
		wb_r <= wb_nxt;
		wc_r <= wc_nxt;
		acc_r <= acc_nxt;
		tmp_r <= tmp_nxt;
		tmp4_r <= tmp4_nxt;
		mq_r <= mq_nxt;
		quot_r <= quot_nxt;
		cnt_r <= cnt_nxt;
		rep_r <= rep_nxt;
		neg_r <= neg_nxt;
	end

	wire logic in_fetch = (state_r == FETCH_A) || (state_r == FETCH_B) || (state_r == FETCH_C);
	wire logic in_write = (state_r == WR_C) || (state_r == WR_REM) || (state_r == WR_SEL) || (state_r == WR_MARK);

	assign order_ready = state_r == IDLE;
	assign mem_req = in_write || (in_fetch && !((state_r == FETCH_A) && (is_buffer || (!need_b && !is_shift))));
	assign mem_we = mem_we_r;
	assign mem_addr = mem_addr_r;
	assign mem_wdata = mem_wdata_r;
	assign order_done = done_r;
	assign call_valid = call_r;
	assign call_addr = call_addr_r;
	assign weight_count_error = wce_r;
	assign result_is_marker = marker_r;
	assign transfer_control_index = idx_r;
	assign transfer_word_count = wcnt_r;
endmodule

// ==== sim/tas_mem_model.sv ====
// Core memory model facing the execution unit, with adjustable acknowledge delay
`timescale 1ns/1ps
module tas_mem_model (
	input wire logic clock,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [10:0] mem_addr,
	input wire logic [51:0] mem_wdata,
	input wire logic [3:0] lat,
	output logic mem_ack,
	output logic [51:0] mem_rdata
);
	logic [51:0] mem [0:2047];
	logic [51:0] last_r = 52'h0;
	logic [3:0] wait_r = 4'h0;
	assign mem_ack = mem_req && (wait_r == lat);
	// Data is only good in the acknowledge cycle; otherwise the inverse of the last word
	assign mem_rdata = mem_ack ? mem[mem_addr] : ~last_r;
	always @(posedge clock) begin
		wait_r <= (mem_req && !mem_ack) ? wait_r + 4'h1 : 4'h0;
		if (mem_ack) begin
			last_r <= mem_rdata;
			if (mem_we) begin
				mem[mem_addr] <= mem_wdata;
			end
		end
	end
endmodule

// ==== sim/tas_exec_unit_monitor.sv ====
// Port assertions of the order execution unit
`timescale 1ns/1ps
module tas_exec_unit_monitor (
	input wire logic clock,
	input wire logic rst,
	input wire logic order_valid,
	input wire logic order_ready,
	input wire logic [51:0] order_word,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [10:0] mem_addr,
	input wire logic [51:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic order_done,
	input wire logic call_valid,
	input wire logic [10:0] call_addr,
	input wire logic weight_count_error,
	input wire logic result_is_marker,
	input wire logic [5:0] transfer_control_index,
	input wire logic [5:0] transfer_word_count
);
	logic wrote_r;
	logic [4:0] idx_w;
	assign idx_w = {order_word[49], order_word[27:24]};
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_take;
		order_valid && order_ready;
	endsequence
	sequence s_wr;
		mem_req && mem_we && mem_ack;
	endsequence
	// Ready comes back together with the done pulse
	sequence s_free;
		order_ready && !$past(order_ready);
	endsequence
	// Set once the running order has stored a word
	always_ff @(posedge clock) begin
		if (rst || (order_valid && order_ready)) begin
			wrote_r <= 1'b0;
		end else if (mem_req && mem_we && mem_ack) begin
			wrote_r <= 1'b1;
		end
	end
	addr_range_a: assert property (mem_req |-> mem_addr <= 11'h7CF)
		else $error("memory address above top location");
	word_count_a: assert property (s_take |=> transfer_word_count ==
		(($past(order_word[20:16]) == 5'h00) ? 6'h20 : {1'b0, $past(order_word[20:16])}))
		else $error("word count field wrong");
	control_index_a: assert property (s_take |=> transfer_control_index ==
		(($past(idx_w) == 5'h00) ? 6'h20 : {1'b0, $past(idx_w)}))
		else $error("control index field wrong");
	call_target_a: assert property (call_valid |-> order_done &&
		(call_addr == tas_pkg::ADDR_OVERFLOW_CALL || call_addr == tas_pkg::ADDR_DIV_FAULT_CALL))
		else $error("call at wrong moment or place");
	call_quiet_a: assert property ((call_valid || weight_count_error) |-> !wrote_r)
		else $error("word stored by a faulted order");
	error_pulse_a: assert property (weight_count_error |-> order_done && !call_valid)
		else $error("weight error outside order end");
	req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we)
		&& $stable(mem_wdata))
		else $error("memory request changed before acknowledge");
	weight_gen_a: assert property (s_wr |-> mem_wdata[3:0] == 4'($countones(mem_wdata[51:4])))
		else $error("stored word has bad weight count");
	done_free_a: assert property (order_done |-> s_free)
		else $error("order port not freed after done");
	take_busy_a: assert property (s_take |=> !order_ready && !order_done)
		else $error("taken order not held busy");
	idle_quiet_a: assert property (order_ready |-> !mem_req)
		else $error("memory request while idle");
	marker_flag_a: assert property (s_wr && !wrote_r |=> result_is_marker == ($past(mem_wdata[51:50]) == 2'h0))
		else $error("marker flag does not match stored result");
endmodule
bind tas_exec_unit tas_exec_unit_monitor u_mon (.clock, .rst, .order_valid, .order_ready, .order_word, .mem_req,
	.mem_we, .mem_addr, .mem_wdata, .mem_ack, .order_done, .call_valid, .call_addr, .weight_count_error,
	.result_is_marker, .transfer_control_index, .transfer_word_count);

// ==== sim/tb.sv ====
// Self-checking bench of the order execution unit
`timescale 1ns/1ps
module tb;
	localparam logic [12:0] BA = 13'h0011;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic order_valid = 1'b0;
	logic [51:0] order_word = 52'h0;
	logic [3:0] lat = 4'h0;
	logic order_ready, mem_req, mem_we, mem_ack, order_done, call_valid, weight_count_error, result_is_marker;
	logic [10:0] mem_addr, call_addr;
	logic [51:0] mem_wdata, mem_rdata;
	logic [5:0] transfer_control_index, transfer_word_count;
	logic [31:0] lf = 32'hEBFF;
	logic [62:0] qw[$];
	logic [25:0] qd[$];
	int error_cnt = 0;
	int n_tests = 0;
	tas_exec_unit u_dut (.clock, .rst, .order_valid, .order_ready, .order_word, .mem_req, .mem_we, .mem_addr,
		.mem_wdata, .mem_ack, .mem_rdata, .order_done, .call_valid, .call_addr, .weight_count_error,
		.result_is_marker, .transfer_control_index, .transfer_word_count);
	tas_mem_model u_mem (.clock, .mem_req, .mem_we, .mem_addr, .mem_wdata, .lat, .mem_ack, .mem_rdata);
	initial begin
		forever #2 clock = ~clock;
	end
	function automatic logic [31:0] nx(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [47:0] bcd(longint v);
		logic [47:0] r;
		for (int i = 0; i < 12; i++) begin
			r[i*4 +: 4] = 4'(v % 10);
			v = v / 10;
		end
		return r;
	endfunction
	function automatic logic [51:0] wd(logic [47:0] d);
		return {d, 4'($countones(d))};
	endfunction
	function automatic logic [51:0] nm(logic s, longint m);
		logic [47:0] b;
		b = bcd(m);
		return wd({3'h0, s, b[43:0]});
	endfunction
	function automatic logic [5:0] c32(logic [4:0] x);
		return (x == 5'h00) ? 6'h20 : {1'b0, x};
	endfunction
	task automatic rnd(output logic [47:0] r);
		repeat (3) begin
			lf = nx(lf);
			r = {r[31:0], lf[15:0]};
		end
	endtask
	task automatic ld(logic [51:0] x, logic [51:0] y);
		u_mem.mem[10] = x;
		u_mem.mem[11] = y;
	endtask
	task automatic ew(int a, logic [51:0] w);
		qw.push_back({11'(a), w});
	endtask
	task automatic ed(logic c, logic e, int ca);
		qd.push_back({1'b0, c, e, 11'(ca), 12'h000});
	endtask
	// Operand A always sits at location 10, inside the lower thousand
	task automatic go(logic [7:0] op, logic [12:0] b, int c);
		logic [47:0] d;
		logic [47:0] cc;
		cc = bcd(c);
		d = {2'h0, b[12], c > 999, op, 12'h010, b[11:0], cc[11:0]};
		@(negedge clock);
		order_word = {d, 4'($countones(d))};
		order_valid = 1'b1;
		@(negedge clock);
		order_valid = 1'b0;
		repeat (3000) begin
			if (order_done) break;
			@(negedge clock);
		end
	endtask
	task automatic cmp_w(logic [62:0] e);
		n_tests++;
		if ({mem_addr, mem_wdata} !== e) begin
			error_cnt++;
			$display("BAD write exp %h got %h", e, {mem_addr, mem_wdata});
		end
	endtask
	task automatic cmp_d(logic [25:0] e);
		logic [25:0] g;
		g = {e[25], call_valid, weight_count_error, e[24] ? call_addr : 11'h000,
			e[25] ? {transfer_control_index, transfer_word_count} : 12'h000};
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD done exp %h got %h", e, g);
		end
	endtask
	task automatic complete_run();
		$display("Checks %0d, errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Outputs are looked at mid-cycle, where every registered value has settled
	always @(negedge clock) begin
		if (!rst && mem_req && mem_we && mem_ack) begin
			cmp_w(qw.size() ? qw.pop_front() : 63'h7FFFFFFFFFFFFFFF);
		end
		if (!rst && order_done) begin
			cmp_d(qd.size() ? qd.pop_front() : 26'h3FFFFFF);
		end
	end
	// About thirty orders of under a hundred cycles each fit well inside this
	initial begin
		#200000;
		error_cnt++;
		complete_run();
	end
	initial begin
		logic [47:0] a, b, c, d, r;
		logic [43:0] k;
		logic [7:0] op;
		logic [12:0] bf;
		logic [39:0] bo;
		int n, e;
		bo = 40'hF3FAEB2077;
		repeat (5) @(posedge clock);
		@(negedge clock);
		rst = 1'b0;
		ld(nm(0, 123), nm(0, 456));
		ew(12, nm(0, 579));
		ed(0, 0, 0);
		go(tas_pkg::OP_SUM, BA, 12);
		ld(nm(0, 64'd99999999999), nm(0, 1));
		ed(1, 0, 1988);
		go(tas_pkg::OP_SUM, BA, 12);
		lat = 4'h3;
		ld(nm(0, 5), nm(0, 8));
		ew(12, nm(1, 3));
		ed(0, 0, 0);
		go(tas_pkg::OP_DIFFERENCE, BA, 12);
		ld(nm(1, 64'd99999999999), nm(0, 1));
		ed(1, 0, 1988);
		go(tas_pkg::OP_DIFFERENCE, BA, 12);
		// Rounding carries out of the lower half
		ld(nm(0, 64'd60000000000), nm(1, 1));
		ew(20, nm(1, 1));
		ew(1995, nm(1, 64'd10000000000));
		ew(1994, wd(bcd(64'd420000000000)));
		ew(1997, wd(bcd(64'd240000000000)));
		ed(0, 0, 0);
		go(tas_pkg::OP_PRODUCT, BA, 20);
		lat = 4'h0;
		ld(nm(0, 2), nm(0, 3));
		ew(1994, nm(0, 0));
		ew(1995, nm(0, 64'd50000000006));
		ew(1997, wd(bcd(8)));
		ed(0, 0, 0);
		go(tas_pkg::OP_PRODUCT, BA, 1994);
		ld(nm(0, 4), nm(0, 1));
		ew(21, nm(0, 64'd25000000000));
		ew(1995, nm(0, 0));
		ed(0, 0, 0);
		go(tas_pkg::OP_QUOTIENT, BA, 21);
		ld(nm(0, 5), nm(1, 5));
		ed(1, 0, 1986);
		go(tas_pkg::OP_QUOTIENT, BA, 21);
		ld(wd(48'h00000000000A), nm(0, 1));
		ed(0, 1, 0);
		go(tas_pkg::OP_PRODUCT, BA, 21);
		ld(nm(0, 1), wd(48'h300000000002));
		ed(0, 1, 0);
		go(tas_pkg::OP_QUOTIENT, BA, 21);
		for (int i = 0; i < 3; i++) begin
			rnd(a);
			rnd(b);
			rnd(c);
			ld(wd(a), wd(b));
			u_mem.mem[22] = wd(c);
			ew(22, wd((a & b) | (c & ~b)));
			ed(0, 0, 0);
			go(tas_pkg::OP_BITWISE_MERGE, BA, 22);
		end
		for (int i = 0; i < 12; i++) begin
			op = 8'h10 + 8'(i % 6);
			rnd(d);
			lf = nx(lf);
			n = (i == 0) ? 0 : (i == 1) ? 12 : int'(lf % 13);
			e = (op > 8'h11 && lf[8]) ? 2 : 0;
			k = op[0] ? d[43:0] >> (4 * n) : d[43:0] << (4 * n);
			r = op[0] ? d >> (4 * n + e) : d << (4 * n + e);
			ld(wd(d), 52'h0);
			ew(23, wd(op < 8'h12 ? {d[47:44], k} : r));
			ed(0, 0, 0);
			go(op, {1'b0, 4'(n), (e != 0) ? 4'h5 : 4'h0, 4'h0}, 23);
		end
		for (int i = 0; i < 5; i++) begin
			lf = nx(lf);
			bf = (i == 0) ? 13'h0000 : lf[12:0];
			qd.push_back({3'h4, 11'h000, c32(bf[12:8]), c32(bf[4:0])});
			go(bo[39 - 8 * i -: 8], bf, 0);
		end
		@(negedge clock);
		n_tests++;
		if (qw.size() + qd.size() != 0) begin
			error_cnt++;
			$display("BAD queues exp 0 got %0d", qw.size() + qd.size());
		end
		complete_run();
	end
endmodule
